// File: rtl/flash_program_erase_control.sv
// The address map and strobed register access were left to the implementer.
`timescale 1ns/10ps
// Functional notes
// - programming works on 128-byte units starting at low byte 00 or 80.
// - an erase clears exactly one block: four 1 kbyte, one 28 kbyte.
// - blocks span 0000-03FF, 0400-07FF, 0800-0BFF, 0C00-0FFF, 1000-7FFF.
// - write-unlock bit 6 gates setting every other control and block bit.
// - bit 5 enters erase-setup; clearing it cancels.
// - bit 4 enters program-setup; clearing it cancels.
// - bit 3 enters erase-verify mode; clearing leaves it.
// - bit 2 enters program-verify mode; clearing leaves it.
// - erase bit 1 enters erase mode only with unlock and erase-setup set.
// - program bit 0 enters program mode only with unlock and program-setup set.
// - bit 7 reads zero; all control bits reset to zero.
// - block select is forced to zero while unlock is zero.
// - writing more than one block select bit clears them all.
// - select bits 4..0 pick 1000-7FFF, 0C00, 0800, 0400, 0000.
module flash_program_erase_control
  import flash_pe_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire flash_pe_pkg::bus_req_type bus_req,
  output logic [7:0] rdata,
  input wire logic [14:0] unit_addr,
  output flash_pe_pkg::mode_type mode,
  output logic [4:0] erase_block,
  output logic [14:0] erase_low,
  output logic [14:0] erase_high,
  output logic unit_aligned
);
  import flash_pe_pkg::*;

  // ==========================================================
  // decode
  logic [6:0] control_reg;
  logic [6:0] control_next;
  logic [4:0] select_reg;
  logic [4:0] select_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [2:0] sel_index;
  wire wr_control = bus_req.wr && (bus_req.addr == ADDR_MODE_CONTROL);
  wire wr_select = bus_req.wr && (bus_req.addr == ADDR_BLOCK_SELECT);
  wire unlock_now = control_reg[BIT_WRITE_UNLOCK];
  wire unlock_new = bus_req.wdata[BIT_WRITE_UNLOCK];
  wire [4:0] sel_wdata = bus_req.wdata[4:0];
  wire sel_multi = (sel_wdata & (sel_wdata - 5'h01)) != 5'h00;

  function automatic logic [2:0] onehot_index(input logic [4:0] v);
    onehot_index = 3'h0;
    for (int i = 0; i < BLOCK_COUNT; i++) begin
      if (v[i]) begin
        onehot_index = 3'(i);
      end
    end
  endfunction : onehot_index

  // ==========================================================
  // mode control register
  // each bit except unlock may only rise while unlock is already held; clears always pass
  always_comb begin
    control_next = control_reg;
    if (wr_control) begin
      control_next[BIT_WRITE_UNLOCK] = unlock_new;
      for (int b = 0; b < BIT_WRITE_UNLOCK; b++) begin
        if (!bus_req.wdata[b]) begin
          control_next[b] = 1'b0;
        end else if (unlock_now) begin
          control_next[b] = 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // erase block select register
  always_comb begin
    select_next = select_reg;
    if (!control_next[BIT_WRITE_UNLOCK]) begin
      select_next = BLOCK_SELECT_RESET;
    end else if (wr_select && unlock_now) begin
      select_next = sel_multi ? BLOCK_SELECT_RESET : sel_wdata;
    end
  end

  always_comb begin
    if (bus_req.addr == ADDR_MODE_CONTROL) begin
      rdata_next = {1'b0, control_reg};
    end else if (bus_req.addr == ADDR_BLOCK_SELECT) begin
      rdata_next = {3'h0, select_reg};
    end else if (bus_req.addr == ADDR_MODE_STATUS) begin
      rdata_next = {2'h0, mode};
    end else if (bus_req.addr == ADDR_BLOCK_LOW) begin
      rdata_next = erase_low[14:7];
    end else if (bus_req.addr == ADDR_BLOCK_HIGH) begin
      rdata_next = erase_high[14:7];
    end else begin
      rdata_next = 8'h00;
    end
    if (!bus_req.rd) begin
      rdata_next = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      control_reg <= MODE_CONTROL_RESET;
      select_reg <= BLOCK_SELECT_RESET;
      rdata_reg <= 8'h00;
    end else begin
      control_reg <= control_next;
      select_reg <= select_next;
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // mode outputs
  // erase and program need their setup bit and unlock held at the same time
  wire erase_entered = control_reg[BIT_ERASE] && unlock_now
    && control_reg[BIT_ERASE_SETUP];
  wire program_entered = control_reg[BIT_PROGRAM] && unlock_now
    && control_reg[BIT_PROGRAM_SETUP];
  // one assignment for the whole struct keeps a single driver on the port
  assign mode = '{
    program_mode: program_entered,
    erase_mode: erase_entered,
    program_verify_mode: control_reg[BIT_PROGRAM_VERIFY],
    erase_verify_mode: control_reg[BIT_ERASE_VERIFY],
    program_setup_state: control_reg[BIT_PROGRAM_SETUP],
    erase_setup_state: control_reg[BIT_ERASE_SETUP]
  };
  assign rdata = rdata_reg;
  assign erase_block = select_reg;
  assign sel_index = onehot_index(select_reg);
  // a zero selection reports an empty range of all zeros
  assign erase_low = (select_reg == 5'h00) ? 15'h0000 : BLOCK_LOW[sel_index];
  assign erase_high = (select_reg == 5'h00) ? 15'h0000 : BLOCK_HIGH[sel_index];
  assign unit_aligned = (unit_addr & UNIT_MASK) == 15'h0000;

  // ==========================================================
  // checks
  property p_locked_no_set;
    @(posedge clk) disable iff (!resetn)
      (wr_control && !unlock_now) |=> ((control_reg[5:0] & ~$past(control_reg[5:0])) == 6'h00);
  endproperty
  a_locked_no_set: assert property (p_locked_no_set) else $error("bit set while locked");

  property p_select_cleared;
    @(posedge clk) disable iff (!resetn)
      !control_reg[BIT_WRITE_UNLOCK] |-> select_reg == 5'h00;
  endproperty
  a_select_cleared: assert property (p_select_cleared) else $error("select while locked");

  property p_select_onehot;
    @(posedge clk) disable iff (!resetn)
      $onehot0(select_reg);
  endproperty
  a_select_onehot: assert property (p_select_onehot) else $error("select not one-hot");

  property p_multi_clears;
    @(posedge clk) disable iff (!resetn)
      (wr_select && unlock_now && sel_multi) |=> select_reg == 5'h00;
  endproperty
  a_multi_clears: assert property (p_multi_clears) else $error("multi select kept");

  property p_erase_gate;
    @(posedge clk) disable iff (!resetn)
      mode.erase_mode |-> (control_reg[BIT_ERASE_SETUP] && control_reg[BIT_WRITE_UNLOCK]);
  endproperty
  a_erase_gate: assert property (p_erase_gate) else $error("erase without setup");

  property p_program_gate;
    @(posedge clk) disable iff (!resetn)
      mode.program_mode |-> (control_reg[BIT_PROGRAM_SETUP] && control_reg[BIT_WRITE_UNLOCK]);
  endproperty
  a_program_gate: assert property (p_program_gate) else $error("program without setup");

  property p_read_control;
    @(posedge clk) disable iff (!resetn)
      (bus_req.rd && bus_req.addr == ADDR_MODE_CONTROL) |=>
        rdata == {1'b0, $past(control_reg)};
  endproperty
  a_read_control: assert property (p_read_control) else $error("control readback");

  property p_clear_cancels;
    @(posedge clk) disable iff (!resetn)
      (wr_control && !bus_req.wdata[BIT_ERASE_SETUP]) |=> !mode.erase_setup_state;
  endproperty
  a_clear_cancels: assert property (p_clear_cancels) else $error("setup not cancelled");

  property p_big_block;
    @(posedge clk) disable iff (!resetn)
      select_reg[4] |-> (erase_low == 15'h1000 && erase_high == 15'h7FFF);
  endproperty
  a_big_block: assert property (p_big_block) else $error("large block range");

  // ==========================================================
  // checks: register writes, mode levels and read path
  property p_unlock_follows;
    @(posedge clk) disable iff (!resetn)
      wr_control |=> control_reg[BIT_WRITE_UNLOCK] == $past(unlock_new);
  endproperty
  a_unlock_follows: assert property (p_unlock_follows) else $error("unlock not written");

  property p_unlocked_sets;
    @(posedge clk) disable iff (!resetn)
      (wr_control && unlock_now) |=> control_reg[5:0] == $past(bus_req.wdata[5:0]);
  endproperty
  a_unlocked_sets: assert property (p_unlocked_sets) else $error("control not held");

  property p_clear_program_setup;
    @(posedge clk) disable iff (!resetn)
      (wr_control && !bus_req.wdata[BIT_PROGRAM_SETUP]) |=> !mode.program_setup_state;
  endproperty
  a_clear_program_setup: assert property (p_clear_program_setup) else $error("psetup kept");

  property p_erase_cancel;
    @(posedge clk) disable iff (!resetn)
      (wr_control && !bus_req.wdata[BIT_ERASE]) |=> !mode.erase_mode;
  endproperty
  a_erase_cancel: assert property (p_erase_cancel) else $error("erase not cancelled");

  property p_program_cancel;
    @(posedge clk) disable iff (!resetn)
      (wr_control && !bus_req.wdata[BIT_PROGRAM]) |=> !mode.program_mode;
  endproperty
  a_program_cancel: assert property (p_program_cancel) else $error("program not cancelled");

  property p_verify_erase;
    @(posedge clk) disable iff (!resetn)
      (wr_control && unlock_now) |=> mode.erase_verify_mode == $past(bus_req.wdata[3]);
  endproperty
  a_verify_erase: assert property (p_verify_erase) else $error("erase verify level");

  property p_verify_program;
    @(posedge clk) disable iff (!resetn)
      (wr_control && unlock_now) |=> mode.program_verify_mode == $past(bus_req.wdata[2]);
  endproperty
  a_verify_program: assert property (p_verify_program) else $error("program verify level");

  property p_read_select;
    @(posedge clk) disable iff (!resetn)
      (bus_req.rd && bus_req.addr == ADDR_BLOCK_SELECT) |=>
        rdata == {3'h0, $past(select_reg)};
  endproperty
  a_read_select: assert property (p_read_select) else $error("select readback");

  property p_read_status;
    @(posedge clk) disable iff (!resetn)
      (bus_req.rd && bus_req.addr == ADDR_MODE_STATUS) |=>
        rdata == {2'h0, $past(mode)};
  endproperty
  a_read_status: assert property (p_read_status) else $error("status readback");

  property p_read_block_low;
    @(posedge clk) disable iff (!resetn)
      (bus_req.rd && bus_req.addr == ADDR_BLOCK_LOW) |=>
        rdata == $past(erase_low[14:7]);
  endproperty
  a_read_block_low: assert property (p_read_block_low) else $error("low readback");

  property p_read_block_high;
    @(posedge clk) disable iff (!resetn)
      (bus_req.rd && bus_req.addr == ADDR_BLOCK_HIGH) |=>
        rdata == $past(erase_high[14:7]);
  endproperty
  a_read_block_high: assert property (p_read_block_high) else $error("high readback");

  // read data stand for one cycle only, so a stale value cannot be mistaken for a fresh read
  property p_read_idle;
    @(posedge clk) disable iff (!resetn)
      !bus_req.rd |=> rdata == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data not idle");

  property p_reset_values;
    @(posedge clk)
      !resetn |=> (control_reg == MODE_CONTROL_RESET && select_reg == BLOCK_SELECT_RESET);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values");

  property p_single_select;
    @(posedge clk) disable iff (!resetn)
      (wr_select && unlock_now && !sel_multi) |=> select_reg == $past(sel_wdata);
  endproperty
  a_single_select: assert property (p_single_select) else $error("single select lost");

  property p_small_blocks;
    @(posedge clk) disable iff (!resetn)
      (select_reg[3:0] != 4'h0) |->
        (erase_high - erase_low) == (BLOCK_HIGH[0] - BLOCK_LOW[0]);
  endproperty
  a_small_blocks: assert property (p_small_blocks) else $error("small block size");

  property p_unit_aligned;
    @(posedge clk) disable iff (!resetn)
      unit_aligned == (unit_addr[7:0] == 8'h00 || unit_addr[7:0] == 8'h80);
  endproperty
  a_unit_aligned: assert property (p_unit_aligned) else $error("unit alignment");

  property p_empty_range;
    @(posedge clk) disable iff (!resetn)
      (select_reg == 5'h00) |-> (erase_low == 15'h0000 && erase_high == 15'h0000);
  endproperty
  a_empty_range: assert property (p_empty_range) else $error("range without block");

  for (genvar g = 0; g < BLOCK_COUNT; g++) begin : g_block_range
    property p_block_range;
      @(posedge clk) disable iff (!resetn)
        select_reg[g] |-> (erase_low == BLOCK_LOW[g] && erase_high == BLOCK_HIGH[g]);
    endproperty
    a_block_range: assert property (p_block_range) else $error("block range");
  end
endmodule : flash_program_erase_control

// File: rtl/flash_pe_pkg.sv
package flash_pe_pkg;
  // ==========================================================
  // register map
  localparam logic [3:0] ADDR_MODE_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_BLOCK_SELECT = 4'h1;
  localparam logic [3:0] ADDR_MODE_STATUS = 4'h2;
  localparam logic [3:0] ADDR_BLOCK_LOW = 4'h3;
  localparam logic [3:0] ADDR_BLOCK_HIGH = 4'h4;
  // ==========================================================
  // mode control fields
  localparam int BIT_PROGRAM = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_PROGRAM_VERIFY = 2;
  localparam int BIT_ERASE_VERIFY = 3;
  localparam int BIT_PROGRAM_SETUP = 4;
  localparam int BIT_ERASE_SETUP = 5;
  localparam int BIT_WRITE_UNLOCK = 6;
  localparam logic [6:0] MODE_CONTROL_RESET = 7'h00;
  localparam logic [4:0] BLOCK_SELECT_RESET = 5'h00;
  // ==========================================================
  // array geometry
  localparam int BLOCK_COUNT = 5;
  localparam logic [14:0] UNIT_MASK = 15'h007F;
  localparam logic [14:0] BLOCK_LOW [BLOCK_COUNT] = '{15'h0000, 15'h0400, 15'h0800,
    15'h0C00, 15'h1000};
  localparam logic [14:0] BLOCK_HIGH [BLOCK_COUNT] = '{15'h03FF, 15'h07FF, 15'h0BFF,
    15'h0FFF, 15'h7FFF};

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  typedef struct packed {
    logic program_mode;
    logic erase_mode;
    logic program_verify_mode;
    logic erase_verify_mode;
    logic program_setup_state;
    logic erase_setup_state;
  } mode_type;
endpackage : flash_pe_pkg

// File: bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import flash_pe_pkg::*;
  logic clk;
  logic resetn;
  bus_req_type bus_req;
  logic [7:0] rdata;
  logic [14:0] unit_addr;
  mode_type mode;
  logic [4:0] erase_block;
  logic [14:0] erase_low;
  logic [14:0] erase_high;
  logic unit_aligned;
  int mismatches;
  int comparisons;
  logic [14:0] ua [5] = '{15'h0000, 15'h0080, 15'h7F80, 15'h0040, 15'h0001};
  logic ua_exp [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  flash_program_erase_control uut (.clk(clk), .resetn(resetn), .bus_req(bus_req),
    .rdata(rdata), .unit_addr(unit_addr), .mode(mode), .erase_block(erase_block),
    .erase_low(erase_low), .erase_high(erase_high), .unit_aligned(unit_aligned));
  // ==========================================================
  // clock, checks and bus access
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(string name, logic [14:0] exp, logic [14:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // driven at a rising edge, taken at the next one, then released;
  // results are looked at on the falling edge, while they still stand
  task automatic access(logic [3:0] a, logic [7:0] d, logic w, logic r);
    @(posedge clk);
    bus_req <= '{a, d, w, r};
    @(posedge clk);
    bus_req <= '0;
    @(negedge clk);
  endtask : access
  task automatic wr(logic [3:0] a, logic [7:0] d);
    access(a, d, 1'b1, 1'b0);
  endtask : wr
  task automatic rd(logic [3:0] a, logic [7:0] exp);
    access(a, 8'h00, 1'b0, 1'b1);
    chk("rdata", {7'h00, exp}, {7'h00, rdata});
  endtask : rd
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  // ==========================================================
  // tests
  initial begin
    resetn = 1'b0;
    bus_req = '0;
    unit_addr = 15'h0000;
    mismatches = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    rd(ADDR_MODE_CONTROL, 8'h00);
    rd(ADDR_BLOCK_SELECT, 8'h00);
    wr(ADDR_MODE_CONTROL, 8'h3F);
    rd(ADDR_MODE_CONTROL, 8'h00);
    wr(ADDR_MODE_CONTROL, 8'h7F);
    rd(ADDR_MODE_CONTROL, 8'h40);
    wr(ADDR_MODE_CONTROL, 8'hC0);
    rd(ADDR_MODE_CONTROL, 8'h40);
    wr(ADDR_MODE_CONTROL, 8'h60);
    chk("mode", 15'h0001, {9'h000, mode});
    wr(ADDR_MODE_CONTROL, 8'h62);
    chk("mode", 15'h0011, {9'h000, mode});
    rd(ADDR_MODE_STATUS, 8'h11);
    rd(ADDR_MODE_CONTROL, 8'h62);
    wr(ADDR_MODE_CONTROL, 8'h22);
    chk("mode", 15'h0001, {9'h000, mode});
    rd(ADDR_MODE_CONTROL, 8'h22);
    wr(ADDR_MODE_CONTROL, 8'h62);
    chk("mode", 15'h0011, {9'h000, mode});
    wr(ADDR_MODE_CONTROL, 8'h60);
    chk("mode", 15'h0001, {9'h000, mode});
    wr(ADDR_MODE_CONTROL, 8'h40);
    chk("mode", 15'h0000, {9'h000, mode});
    wr(ADDR_MODE_CONTROL, 8'h41);
    chk("mode", 15'h0000, {9'h000, mode});
    wr(ADDR_MODE_CONTROL, 8'h50);
    chk("mode", 15'h0002, {9'h000, mode});
    wr(ADDR_MODE_CONTROL, 8'h51);
    chk("mode", 15'h0022, {9'h000, mode});
    wr(ADDR_MODE_CONTROL, 8'h50);
    chk("mode", 15'h0002, {9'h000, mode});
    wr(ADDR_MODE_CONTROL, 8'h4C);
    chk("mode", 15'h000C, {9'h000, mode});
    wr(ADDR_MODE_CONTROL, 8'h40);
    chk("mode", 15'h0000, {9'h000, mode});
    for (int i = 0; i < BLOCK_COUNT; i++) begin
      wr(ADDR_BLOCK_SELECT, 8'(1 << i));
      chk("erase_block", 15'(1 << i), {10'h000, erase_block});
      chk("erase_low", BLOCK_LOW[i], erase_low);
      chk("erase_high", BLOCK_HIGH[i], erase_high);
      rd(ADDR_BLOCK_LOW, BLOCK_LOW[i][14:7]);
      rd(ADDR_BLOCK_HIGH, BLOCK_HIGH[i][14:7]);
    end
    wr(ADDR_BLOCK_SELECT, 8'h03);
    rd(ADDR_BLOCK_SELECT, 8'h00);
    chk("erase_low", 15'h0000, erase_low);
    wr(ADDR_BLOCK_SELECT, 8'h10);
    wr(ADDR_MODE_CONTROL, 8'h00);
    chk("erase_block", 15'h0000, {10'h000, erase_block});
    wr(ADDR_BLOCK_SELECT, 8'h01);
    rd(ADDR_BLOCK_SELECT, 8'h00);
    rd(4'h5, 8'h00);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      unit_addr <= ua[i];
      @(negedge clk);
      chk("unit_aligned", {14'h0000, ua_exp[i]}, {14'h0000, unit_aligned});
    end
    wrap_up();
  end
  // the tests need under 200 cycles; the limit allows five times that
  initial begin
    #20000;
    mismatches++;
    wrap_up();
  end
endmodule : tb_top
